// ### src/env_sensor_mode_sequencer.sv
// mode control and measurement sequencer with ahb-lite registers
// What this block does
// RULE1: mode 00 sleeps, 01 runs forced cycle
// RULE2: enters sleep on its own after reset
// RULE3: mode change during measurement waits for end
// RULE4: pending mode change drops all control writes
// RULE5: host sets all controls before mode write
// RULE6: forced runs one cycle, then back to sleep
// RULE7: heater powered only in gas phase
// RULE8: order is temperature, pressure, humidity, gas
// RULE9: ten heater profiles, set-point plus duration
// RULE10: oversampling 16x down to 0x, 0x skips
// RULE11: humidity code 001 means one-times
// RULE12: temperature code 010 means two-times
// RULE13: pressure code 101 means sixteen-times
// RULE14: host writes humidity first, then t and p
// RULE15: profile index selects heater profile, 0 first
// RULE16: gas phase only when gas-run bit set
// RULE17: duration code 59h heats for 100 ms
// RULE18: writing 01 to mode starts a cycle
// RULE19: heating after humidity, then gas measured
//
// Implementation choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module env_sensor_mode_sequencer
  import env_seq_pkg::*;
#(
  parameter int unsigned HEAT_MS_CYCLES = HEAT_MS_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // sensor front end
  output sensor_out_t sensor
);
  localparam logic [15:0] MS_CNT = 16'(HEAT_MS_CYCLES);

  seq_regs_t s_reg, s_next;
  logic [15:0] prof_rdata;
  logic [3:0] mem_raddr;
  logic bus_prof_rd;
  logic mem_we;
  logic wr;

  // ==================================================
  // decode helpers
  function automatic logic prof_hit(input logic [7:0] a);
    return a >= OFS_PROF_BASE && a < OFS_PROF_END;
  endfunction

  function automatic logic [3:0] prof_of(input logic [7:0] a);
    logic [7:0] d;
    d = a - OFS_PROF_BASE;
    return d[5:2];
  endfunction

  function automatic logic [4:0] samples(input logic [2:0] c);
    unique case (c)
      OSRS_SKIP: return 5'h00;
      OSRS_X1: return 5'h01;
      OSRS_X2: return 5'h02;
      OSRS_X4: return 5'h04;
      OSRS_X8: return 5'h08;
      default: return 5'h10;
    endcase
  endfunction

  function automatic logic [15:0] conv_len(input logic [2:0] c);
    return 16'(samples(c) * SAMPLE_CYC);
  endfunction

  // wait code: six-bit value times 1, 4, 16 or 64 ms
  function automatic logic [11:0] heat_ms(input logic [7:0] c);
    return 12'(c[5:0]) << {c[7:6], 1'b0};
  endfunction

  function automatic seq_state_t stage(input int i);
    unique case (i)
      0: return ST_TEMP;
      1: return ST_PRES;
      2: return ST_HUM;
      default: return ST_LOAD;
    endcase
  endfunction

  // first enabled stage at or after from
  function automatic seq_state_t pick(input seq_regs_t r,
                                      input int from);
    logic [3:0] en;
    seq_state_t q;
    en = {r.run_gas, samples(r.osrs_h) != 5'h00,
          samples(r.osrs_p) != 5'h00, samples(r.osrs_t) != 5'h00};
    q = ST_FINISH;
    for (int i = 3; i >= 0; i--) begin
      if (en[i] && i >= from) begin
        q = stage(i);
      end
    end
    return q;
  endfunction

  // ==================================================
  // profile memory
  assign bus_prof_rd = hsel && hready && htrans[1] && !hwrite &&
                       haddr[31:8] == 24'h0 && prof_hit(haddr[7:0]);
  assign wr = s_reg.dph_valid && s_reg.dph_write && s_reg.dph_ok;
  assign mem_we = wr && !s_reg.pend && s_reg.dph_prof; // RULE4
  // bus reads win; the sequencer stays in load while a bus read hits the profiles
  assign mem_raddr = bus_prof_rd ? prof_of(haddr[7:0])
                                 : s_reg.prof_idx; // RULE15

  heater_profile_mem u_prof (
    .hclk(hclk),
    .hresetn(hresetn),
    .we(mem_we), // RULE9
    .waddr(prof_of(s_reg.dph_addr)),
    .wdata(hwdata[15:0]),
    .raddr(mem_raddr),
    .rdata(prof_rdata)
  );

  // ==================================================
  // next state
  always_comb begin
    logic start;
    logic [1:0] m;
    logic [11:0] ms;
    start = 1'b0;
    m = hwdata[MODE_LSB +: 2];
    ms = 12'h000;
    s_next = s_reg;
    s_next.done = 1'b0;
    // address phase capture
    s_next.dph_valid = hsel && hready && htrans[1];
    s_next.dph_write = hwrite;
    s_next.dph_addr = haddr[7:0];
    s_next.dph_ok = haddr[31:8] == 24'h0 && haddr[1:0] == 2'h0;
    s_next.dph_prof = prof_hit(haddr[7:0]);
    // data phase write, dropped while a mode change waits
    if (wr && !s_reg.pend) begin // RULE4
      unique case (s_reg.dph_addr)
        OFS_CTRL_HUM: s_next.osrs_h = hwdata[OSRS_H_LSB +: 3];
        OFS_CTRL_MEAS: begin
          s_next.osrs_t = hwdata[OSRS_T_LSB +: 3];
          s_next.osrs_p = hwdata[OSRS_P_LSB +: 3];
          if (s_reg.state == ST_SLEEP) begin
            s_next.mode = m;
            start = m == MODE_FORCED; // RULE18
          end else begin
            s_next.pend = 1'b1; // RULE3
            s_next.pend_mode = m;
          end
        end
        OFS_CTRL_GAS: begin
          s_next.prof_idx = hwdata[PROF_IDX_LSB +: 4];
          s_next.run_gas = hwdata[RUN_GAS_BIT];
        end
        default: begin
        end
      endcase
    end
    // sequencer
    s_next.cnt = s_reg.cnt - 16'h0001;
    unique case (s_reg.state)
      ST_SLEEP: begin
        if (start) begin
          s_next.state = pick(s_next, 0); // RULE1 RULE10
        end
      end
      ST_TEMP: begin
        if (s_reg.cnt == 16'h0001) begin
          s_next.state = pick(s_next, 1); // RULE8
        end
      end
      ST_PRES: begin
        if (s_reg.cnt == 16'h0001) begin
          s_next.state = pick(s_next, 2); // RULE8
        end
      end
      ST_HUM: begin
        if (s_reg.cnt == 16'h0001) begin
          s_next.state = pick(s_next, 3); // RULE8 RULE16
        end
      end
      ST_LOAD: begin
        if (!bus_prof_rd) begin
          s_next.state = ST_GRAB;
        end
      end
      ST_GRAB: begin
        s_next.setpoint = prof_rdata[PROF_SET_LSB +: 8]; // RULE15
        ms = heat_ms(prof_rdata[PROF_WAIT_LSB +: 8]); // RULE17
        s_next.ms_cnt = ms;
        s_next.cnt = MS_CNT;
        s_next.state = ms == 12'h000 ? ST_GAS : ST_HEAT; // RULE19
      end
      ST_HEAT: begin
        if (s_reg.cnt == 16'h0001) begin
          s_next.cnt = MS_CNT;
          s_next.ms_cnt = s_reg.ms_cnt - 12'h001;
          if (s_reg.ms_cnt == 12'h001) begin
            s_next.state = ST_GAS; // RULE19
          end
        end
      end
      ST_GAS: begin
        if (s_reg.cnt == 16'h0001) begin
          s_next.state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        s_next.done = 1'b1;
        s_next.mode = MODE_SLEEP; // RULE6
        s_next.state = ST_SLEEP;
        // a mode write landing in this last cycle runs now, not stranded
        if (s_next.pend) begin
          s_next.pend = 1'b0; // RULE3
          s_next.mode = s_next.pend_mode;
          if (s_next.pend_mode == MODE_FORCED) begin
            s_next.state = pick(s_next, 0);
          end
        end
      end
      default: s_next.state = ST_SLEEP;
    endcase
    // conversion length taken on entry
    if (s_next.state != s_reg.state) begin
      unique case (s_next.state)
        ST_TEMP: s_next.cnt = conv_len(s_next.osrs_t); // RULE12
        ST_PRES: s_next.cnt = conv_len(s_next.osrs_p); // RULE13
        ST_HUM: s_next.cnt = conv_len(s_next.osrs_h); // RULE11
        ST_GAS: s_next.cnt = 16'(GAS_CYC);
        default: begin
        end
      endcase
    end
    // read data reflect this cycle's write
    s_next.rdata = 32'h0000_0000;
    if (haddr[31:8] == 24'h0) begin
      unique case (haddr[7:0])
        OFS_CTRL_HUM: s_next.rdata[OSRS_H_LSB +: 3] = s_next.osrs_h;
        OFS_CTRL_MEAS: begin
          s_next.rdata[OSRS_T_LSB +: 3] = s_next.osrs_t;
          s_next.rdata[OSRS_P_LSB +: 3] = s_next.osrs_p;
          s_next.rdata[MODE_LSB +: 2] = s_next.mode;
        end
        OFS_CTRL_GAS: begin
          s_next.rdata[PROF_IDX_LSB +: 4] = s_next.prof_idx;
          s_next.rdata[RUN_GAS_BIT] = s_next.run_gas;
        end
        OFS_STATUS: begin
          s_next.rdata[STAT_BUSY_BIT] = s_reg.state != ST_SLEEP;
          s_next.rdata[STAT_PEND_BIT] = s_reg.pend;
          s_next.rdata[STAT_HEAT_BIT] = sensor.heater_on;
          s_next.rdata[STAT_STATE_LSB +: 4] = s_reg.state;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0; // RULE2
      s_reg.state <= ST_SLEEP;
      s_reg.mode <= MODE_SLEEP;
      s_reg.osrs_t <= RST_OSRS;
      s_reg.osrs_p <= RST_OSRS;
      s_reg.osrs_h <= RST_OSRS;
      s_reg.prof_idx <= RST_PROF_IDX;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==================================================
  // outputs
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = s_reg.dph_prof && s_reg.dph_ok
                ? {16'h0000, prof_rdata} : s_reg.rdata;

  always_comb begin
    sensor = '0;
    sensor.busy = s_reg.state != ST_SLEEP;
    sensor.conv_temp = s_reg.state == ST_TEMP;
    sensor.conv_pres = s_reg.state == ST_PRES;
    sensor.conv_hum = s_reg.state == ST_HUM;
    sensor.conv_gas = s_reg.state == ST_GAS;
    // plate only hot while heating and sensing gas
    sensor.heater_on = s_reg.state == ST_HEAT ||
                       s_reg.state == ST_GAS; // RULE7
    sensor.heater_setpoint = s_reg.setpoint;
    sensor.cycle_done = s_reg.done;
  end

  // ==================================================
  // assertions
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sleep_quiet_a: assert property ( // RULE1
    s_reg.state == ST_SLEEP |-> !sensor.conv_temp &&
      !sensor.conv_pres && !sensor.conv_hum && !sensor.heater_on)
    else $error("activity while asleep");
  reset_sleep_a: assert property ( // RULE2
    @(posedge hclk) disable iff (1'b0)
    !hresetn |=> s_reg.state == ST_SLEEP && !sensor.busy)
    else $error("not asleep after reset");
  mode_defer_a: assert property ( // RULE3
    wr && !s_reg.pend && s_reg.dph_addr == OFS_CTRL_MEAS &&
    s_reg.state inside {ST_TEMP, ST_PRES, ST_HUM}
    |=> s_reg.pend && s_reg.state != ST_SLEEP)
    else $error("mode change not held");
  pend_drop_a: assert property ( // RULE4
    wr && s_reg.pend |=> $stable(s_reg.prof_idx) &&
      $stable(s_reg.osrs_h) && $stable(s_reg.pend_mode))
    else $error("write taken while pending");
  one_cycle_a: assert property ( // RULE6
    s_reg.state == ST_FINISH && !s_reg.pend &&
    !(wr && s_reg.dph_addr == OFS_CTRL_MEAS)
    |=> s_reg.state == ST_SLEEP && s_reg.mode == MODE_SLEEP
      && sensor.cycle_done)
    else $error("forced cycle did not end in sleep");
  heater_gas_a: assert property ( // RULE7
    $rose(sensor.heater_on) |-> $past(s_reg.state) == ST_GRAB)
    else $error("heater on outside gas phase");
  order_a: assert property ( // RULE8
    $fell(sensor.conv_hum) |-> s_reg.state inside {ST_LOAD, ST_FINISH})
    else $error("bad stage after humidity");
  hum_x1_a: assert property ( // RULE11
    $rose(sensor.conv_hum) && s_reg.osrs_h == OSRS_X1
    |-> s_reg.cnt == 16'(SAMPLE_CYC))
    else $error("humidity x1 length wrong");
  temp_x2_a: assert property ( // RULE12
    $rose(sensor.conv_temp) && s_reg.osrs_t == OSRS_X2
    |-> s_reg.cnt == 16'(2 * SAMPLE_CYC))
    else $error("temperature x2 length wrong");
  pres_x16_a: assert property ( // RULE13
    $rose(sensor.conv_pres) && s_reg.osrs_p == OSRS_X16
    |-> s_reg.cnt == 16'(16 * SAMPLE_CYC))
    else $error("pressure x16 length wrong");
  skip_t_a: assert property ( // RULE10
    $rose(sensor.busy) && s_reg.osrs_t == OSRS_SKIP
    |-> !sensor.conv_temp)
    else $error("skipped temperature ran");
  heat_ms_a: assert property ( // RULE17
    s_reg.state == ST_GRAB && prof_rdata[15:8] == 8'h59
    |=> s_reg.ms_cnt == 12'h064 && sensor.heater_on)
    else $error("duration code not decoded");
  gas_skip_a: assert property ( // RULE16
    !s_next.run_gas && s_reg.state == ST_HUM |=> s_reg.state != ST_LOAD)
    else $error("gas ran while disabled");
  start_a: assert property ( // RULE18
    s_reg.state == ST_SLEEP && wr && !s_reg.pend &&
    s_reg.dph_addr == OFS_CTRL_MEAS &&
    hwdata[1:0] == MODE_FORCED |=> sensor.busy)
    else $error("forced write did not start");

  full_cycle_c: cover property ($rose(sensor.conv_gas));
  pend_run_c: cover property (s_reg.pend && s_reg.state == ST_FINISH);
  heat_c: cover property ($fell(sensor.heater_on));
endmodule
`default_nettype wire

// ### src/env_seq_pkg.sv
// shared constants and types of the sensor mode sequencer
package env_seq_pkg;
  // ==================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned SAMPLE_TIME_NS = 2000;
  localparam int unsigned SAMPLE_CYC =
    (SAMPLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GAS_TIME_NS = 5000;
  localparam int unsigned GAS_CYC =
    (GAS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HEAT_STEP_NS = 1000000;
  localparam int unsigned HEAT_MS_CYC =
    (HEAT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==================================================
  // register offsets
  localparam logic [7:0] OFS_CTRL_HUM = 8'h00;
  localparam logic [7:0] OFS_CTRL_MEAS = 8'h04;
  localparam logic [7:0] OFS_CTRL_GAS = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_PROF_BASE = 8'h40;
  localparam logic [7:0] OFS_PROF_END = 8'h68;
  localparam logic [3:0] PROF_COUNT = 4'ha;
  // ==================================================
  // field positions
  localparam int MODE_LSB = 0;
  localparam int OSRS_P_LSB = 2;
  localparam int OSRS_T_LSB = 5;
  localparam int OSRS_H_LSB = 0;
  localparam int PROF_IDX_LSB = 0;
  localparam int RUN_GAS_BIT = 4;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_PEND_BIT = 1;
  localparam int STAT_HEAT_BIT = 2;
  localparam int STAT_STATE_LSB = 4;
  localparam int PROF_SET_LSB = 0;
  localparam int PROF_WAIT_LSB = 8;
  // ==================================================
  // codes and reset values
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_FORCED = 2'h1;
  localparam logic [2:0] OSRS_SKIP = 3'h0;
  localparam logic [2:0] OSRS_X1 = 3'h1;
  localparam logic [2:0] OSRS_X2 = 3'h2;
  localparam logic [2:0] OSRS_X4 = 3'h3;
  localparam logic [2:0] OSRS_X8 = 3'h4;
  localparam logic [2:0] OSRS_X16 = 3'h5;
  localparam logic [2:0] RST_OSRS = 3'h0;
  localparam logic [3:0] RST_PROF_IDX = 4'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  // ==================================================
  // types
  typedef enum logic [3:0] {
    ST_SLEEP, ST_TEMP, ST_PRES, ST_HUM, ST_LOAD,
    ST_GRAB, ST_HEAT, ST_GAS, ST_FINISH
  } seq_state_t;

  typedef struct packed {
    logic busy;
    logic conv_temp;
    logic conv_pres;
    logic conv_hum;
    logic conv_gas;
    logic heater_on;
    logic [7:0] heater_setpoint;
    logic cycle_done;
  } sensor_out_t;

  typedef struct packed {
    seq_state_t state;
    logic [1:0] mode;
    logic [2:0] osrs_t;
    logic [2:0] osrs_p;
    logic [2:0] osrs_h;
    logic [3:0] prof_idx;
    logic run_gas;
    logic pend;
    logic [1:0] pend_mode;
    logic [15:0] cnt;
    logic [11:0] ms_cnt;
    logic [7:0] setpoint;
    logic done;
    logic dph_valid;
    logic dph_write;
    logic dph_ok;
    logic dph_prof;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } seq_regs_t;

  typedef struct packed {
    logic [9:0][15:0] mem;
    logic [15:0] rdata;
  } prof_mem_t;
endpackage

// ### src/heater_profile_mem.sv
// ten heater profiles, registered read, write-first
`timescale 1ns/1ps
`default_nettype none
module heater_profile_mem
  import env_seq_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // write port
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [15:0] wdata,
  // read port
  input wire logic [3:0] raddr,
  output logic [15:0] rdata
);
  prof_mem_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (we && waddr < PROF_COUNT) begin
      s_next.mem[waddr] = wdata;
    end
    // indices past the last profile read as zero
    if (raddr < PROF_COUNT) begin
      s_next.rdata = s_next.mem[raddr];
    end else begin
      s_next.rdata = 16'h0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata = s_reg.rdata;
endmodule
`default_nettype wire

// ### bench/host_bus_master.sv
// ahb-lite host model issuing single word transfers
`timescale 1ns/1ps
`default_nettype none
module host_bus_master
  import env_seq_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite master side
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // ==========================================
  // idle bus at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ==========================================
  // one transfer; each phase stands until hready is seen
  task automatic xfer(input logic wr, input logic [31:0] addr,
    input logic [31:0] wdata, output logic [31:0] rdata);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    haddr <= ~addr;
    // reads invert hwdata, which puts the last write data back on the bus
    hwdata <= wr ? wdata : ~hwdata;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rdata = hrdata;
    hwdata <= ~hwdata;
  endtask
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench of the sensor mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import env_seq_pkg::*;
;
  // ==========================================
  // signals
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  sensor_out_t sensor;
  int mismatches = 0;
  int samples_checked = 0;
  int cnt [6];
  int rank = 0;
  logic bad_ord = 1'b0;
  logic bad_heat = 1'b0;
  logic [7:0] sp_seen = 8'h0;
  logic [31:0] rd;
  // addr, write data, read back
  logic [31:0] rows [8][3] = '{
    '{32'h00, 32'h01, 32'h01},
    '{32'h04, 32'h54, 32'h54},
    '{32'h08, 32'h10, 32'h10},
    '{32'h40, 32'h59a5, 32'h59a5},
    '{32'h64, 32'hffff423c, 32'h423c},
    '{32'h68, 32'h1234, 32'h0},
    '{32'h80, 32'hffff, 32'h0},
    '{32'h0c, 32'hff, 32'h0}
  };
  assign hready = hreadyout;
  always #10 hclk = ~hclk;
  // ==========================================
  // instances
  env_sensor_mode_sequencer #(.HEAT_MS_CYCLES(5)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .sensor(sensor));
  host_bus_master host (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata));
  // ==========================================
  // phase monitor: counts cycles, tracks order
  task automatic note(input int r);
    cnt[r]++;
    // a new cycle may follow the gas phase directly
    if (rank > r && rank < 5) bad_ord = 1'b1;
    rank = r;
  endtask
  always @(posedge hclk) begin
    if (hresetn === 1'b1) begin
      if (sensor.busy !== 1'b1) rank = 0;
      if (sensor.cycle_done === 1'b1) cnt[0]++;
      if (sensor.conv_temp === 1'b1) note(1);
      if (sensor.conv_pres === 1'b1) note(2);
      if (sensor.conv_hum === 1'b1) note(3);
      if (sensor.heater_on === 1'b1 && sensor.conv_gas !== 1'b1) note(4);
      if (sensor.conv_gas === 1'b1) note(5);
      if (sensor.heater_on === 1'b1) sp_seen = sensor.heater_setpoint;
      if (sensor.conv_gas === 1'b1 && sensor.heater_on !== 1'b1)
        bad_heat = 1'b1;
      if (sensor.heater_on !== 1'b0 && (sensor.busy !== 1'b1 ||
          sensor.conv_temp || sensor.conv_pres || sensor.conv_hum))
        bad_heat = 1'b1;
    end
  end
  // ==========================================
  // shared tasks
  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [31:0] a, d);
    host.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input string n, input logic [31:0] a, e);
    host.xfer(1'b0, a, 32'h0, rd);
    check(n, e, rd);
  endtask
  task automatic clr;
    foreach (cnt[i]) cnt[i] = 0;
    sp_seen = 8'h0;
  endtask
  task automatic finish_cycle(input int t, p, h, ht, g,
    input logic [7:0] sp, input int dn);
    int k;
    k = 0;
    @(negedge hclk);
    while (sensor.busy !== 1'b0 && k < 20000) begin
      @(negedge hclk);
      k++;
    end
    repeat (2) @(negedge hclk);
    if (k >= 20000) mismatches++;
    check("temp cycles", t, cnt[1]);
    check("pres cycles", p, cnt[2]);
    check("hum cycles", h, cnt[3]);
    check("heat cycles", ht, cnt[4]);
    check("gas cycles", g, cnt[5]);
    check("set-point", sp, sp_seen);
    check("cycles done", dn, cnt[0]);
    check("order", 1'b0, bad_ord);
    check("heater", 1'b0, bad_heat);
  endtask
  task tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog, well past the longest run
  initial begin
    #(40000 * CLK_PERIOD_NS);
    mismatches++;
    tally_and_finish;
  end
  // ==========================================
  // main sequence
  initial begin
    clr();
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    check("busy after reset", 1'b0, sensor.busy);
    rdc("status after reset", 32'h0c, 32'h0);
    rdc("mode after reset", 32'h04, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][0], rows[i][1]);
      rdc("register", rows[i][0], rows[i][2]);
    end
    check("sleep stays idle", 1'b0, sensor.busy);
    clr();
    wr(32'h04, 32'h55);
    repeat (20) @(posedge hclk);
    wr(32'h04, 32'h55);
    wr(32'h00, 32'h07);
    host.xfer(1'b0, 32'h0c, 32'h0, rd);
    check("busy and pending", 32'h3, rd & 32'h3);
    rdc("dropped write", 32'h00, 32'h01);
    check("response", HRESP_OKAY, hresp);
    finish_cycle(400, 3200, 200, 1000, 500, 8'ha5, 2);
    rdc("mode back to sleep", 32'h04, 32'h54);
    rdc("status idle", 32'h0c, 32'h0);
    wr(32'h08, 32'h19);
    wr(32'h00, 32'h00);
    clr();
    wr(32'h04, 32'h21);
    finish_cycle(100, 0, 0, 40, 250, 8'h3c, 1);
    wr(32'h08, 32'h00);
    clr();
    wr(32'h04, 32'h01);
    finish_cycle(0, 0, 0, 0, 0, 8'h0, 1);
    tally_and_finish;
  end
endmodule
`default_nettype wire
